// ---- inc/cpsq_pkg.sv ----
// shared constants for the channel program store/subtract/queue executor
package cpsq_pkg;
  // opcodes (high nibble = format row, low nibble = column)
  localparam logic [7:0] OP_ST_R_LCT = 8'h51;
  localparam logic [7:0] OP_ST_B_LCT = 8'h71;
  localparam logic [7:0] OP_ST_R_NDX = 8'h81;
  localparam logic [7:0] OP_ST_EXT = 8'hC1;
  localparam logic [7:0] OP_SUB_R_LCT = 8'h59;
  localparam logic [7:0] OP_SUB_B_LCT = 8'h79;
  localparam logic [7:0] OP_SUB_R_NDX = 8'h89;
  localparam logic [7:0] OP_SUB_R_IMM = 8'h99;
  localparam logic [7:0] OP_SUB_B_IMM = 8'hB9;
  localparam logic [7:0] OP_TLU = 8'h56;
  localparam logic [7:0] OP_TQE = 8'hAC;
  localparam logic [7:0] OP_TQF = 8'hAD;
  localparam logic [7:0] OP_WAIT = 8'h01;
  localparam logic [7:0] QUEUE_FULL_BIAS = 8'h0F;
  localparam int CFG_A_EXT_BIT = 4;
  // timing in picoseconds, cycles derived at 5 ns
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_BASIC_PS = 750000;
  localparam int T_TQF_PS = 1100000;
  localparam int T_EXT_PS = 6800000;
  localparam int T_TLU_PS = 6000000;
  localparam int T_TLU_MAX_PS = 7500000;
  localparam int T_WAIT_PS = 13250000;
  localparam int CYC_BASIC = (T_BASIC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_TQF = (T_TQF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_EXT = (T_EXT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_TLU = (T_TLU_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_WAIT = (T_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 12;
  typedef enum logic [2:0] {
    CPSQ_IDLE = 3'b000,
    CPSQ_EXEC = 3'b001,
    CPSQ_DONE = 3'b011,
    CPSQ_SCAN = 3'b010
  } cpsq_state_t;
endpackage

// ---- logic/cpsq_sub.sv ----
// 8-bit subtractor producing inverted-borrow carry, sign and zero
`timescale 1ns/1ps
module cpsq_sub import cpsq_pkg::*; #(
  parameter int W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic [W-1:0] c,
  output logic [W-1:0] diff,
  output logic carry,
  output logic sign,
  output logic zero
);
  wire logic [W:0] wide;
  // a - b - c; carry is one when no borrow occurs
  assign wide = {1'b0, a} - {1'b0, b} - {1'b0, c};
  assign diff = wide[W-1:0];
  assign carry = ~wide[W];
  assign sign = wide[W-1];
  assign zero = (wide[W-1:0] == '0);
endmodule

// ---- logic/cpsq_scan.sv ----
// fixed-priority service request scan, lowest index wins
`timescale 1ns/1ps
module cpsq_scan import cpsq_pkg::*; #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  output logic [$clog2(N)-1:0] winner,
  output logic any
);
  logic [$clog2(N)-1:0] w;
  always_comb begin
    w = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        w = i[$clog2(N)-1:0];
      end
    end
  end
  assign winner = w;
  assign any = |req;
endmodule

// ---- logic/cpsq_exec.sv ----
// executes store, subtract, table look-up, queue tests and wait
`timescale 1ns/1ps
module cpsq_exec import cpsq_pkg::*; #(
  parameter int NCH = 16,
  parameter int CW = $clog2(NCH)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] queue_head_ptr,
  input wire logic [7:0] queue_tail_ptr,
  input wire logic config_a_order,
  input wire logic [7:0] config_a_data,
  input wire logic [NCH-1:0] service_req,
  input wire logic [CW-1:0] active_channel,
  input wire logic [15:0] channel_program,
  input wire logic [7:0] lct_rdata,
  input wire logic [7:0] ram_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] acc,
  output logic [7:0] index,
  output logic carry_flag,
  output logic sign_flag,
  output logic zero_flag,
  output logic lct_we,
  output logic lct_re,
  output logic [7:0] lct_addr,
  output logic [7:0] lct_wdata,
  output logic ram_we,
  output logic ram_re,
  output logic [11:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ctx_save,
  output logic ctx_restore,
  output logic [CW-1:0] ctx_channel,
  output logic [15:0] ctx_program,
  output logic grant_valid,
  output logic [CW-1:0] grant_channel
);
  logic rst_s1, rst_s2;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire logic rstn = rst_s2;
  cpsq_state_t state, next_state;
  logic [7:0] op, opnd, ptr_lo;
  logic [CNT_W-1:0] cnt, wait_age;
  logic [2:0] step;
  logic ext_enable;
  logic [CW-1:0] saved_ch [NCH];
  logic [15:0] saved_prog [NCH];
  logic [NCH-1:0] suspended;
  // opcode decode
  wire logic is_st_r = (op == OP_ST_R_LCT);
  wire logic is_st_b = (op == OP_ST_B_LCT);
  wire logic is_st_n = (op == OP_ST_R_NDX);
  wire logic is_st_x = (op == OP_ST_EXT);
  wire logic is_sub_rl = (op == OP_SUB_R_LCT);
  wire logic is_sub_bl = (op == OP_SUB_B_LCT);
  wire logic is_sub_n = (op == OP_SUB_R_NDX);
  wire logic is_sub_ri = (op == OP_SUB_R_IMM);
  wire logic is_sub_bi = (op == OP_SUB_B_IMM);
  wire logic is_tlu = (op == OP_TLU);
  wire logic is_tqe = (op == OP_TQE);
  wire logic is_tqf = (op == OP_TQF);
  wire logic is_wait = (op == OP_WAIT);
  wire logic is_sub = is_sub_rl | is_sub_bl | is_sub_n | is_sub_ri
                    | is_sub_bi;
  wire logic in_b = is_sub_bl | is_sub_bi;
  wire logic imm = is_sub_ri | is_sub_bi;
  wire logic known = is_st_r | is_st_b | is_st_n | is_st_x | is_sub
                   | is_tlu | is_tqe | is_tqf | is_wait;
  wire logic bad_op = !known | (is_st_x & !ext_enable);

  wire logic [CNT_W-1:0] op_cycles =
    is_st_x ? CNT_W'(CYC_EXT) :
    is_tlu ? CNT_W'(CYC_TLU) :
    is_tqf ? CNT_W'(CYC_TQF) :
    is_wait ? CNT_W'(CYC_WAIT) : CNT_W'(CYC_BASIC);

  // operand sources for the shared subtractor
  wire logic [7:0] sub_a = is_tqe | is_tqf ? queue_head_ptr
                         : (in_b ? index : acc);
  wire logic [7:0] sub_b = is_tqe | is_tqf ? queue_tail_ptr
                         : (imm ? opnd : ptr_lo);
  wire logic [7:0] sub_c = is_tqf ? QUEUE_FULL_BIAS : 8'h00;
  logic [7:0] diff;
  logic s_carry, s_sign, s_zero;
  cpsq_sub #(.W(8)) u_sub (
    .a(sub_a),
    .b(sub_b),
    .c(sub_c),
    .diff(diff),
    .carry(s_carry),
    .sign(s_sign),
    .zero(s_zero)
  );

  logic [CW-1:0] win;
  logic win_any;
  cpsq_scan #(.N(NCH)) u_scan (
    .req(service_req),
    .winner(win),
    .any(win_any)
  );

  wire logic last = (cnt == CNT_W'(1));
  wire logic [11:0] tlu_ptr = {lct_rdata[3:0], ptr_lo} + {4'h0, acc};
  wire logic resume = win_any & suspended[win];
  always_comb begin
    next_state = state;
    unique case (state)
      CPSQ_IDLE: if (start) next_state = CPSQ_EXEC;
      CPSQ_EXEC: begin
        if (bad_op) next_state = CPSQ_DONE;
        else if (last) next_state = is_wait ? CPSQ_SCAN : CPSQ_DONE;
      end
      CPSQ_SCAN: if (win_any) next_state = CPSQ_DONE;
      CPSQ_DONE: next_state = CPSQ_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_enable <= 1'b0;
    end else if (config_a_order) begin
      ext_enable <= config_a_data[CFG_A_EXT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CPSQ_IDLE;
      op <= 8'h00;
      opnd <= 8'h00;
      cnt <= '0;
      step <= 3'd0;
      ptr_lo <= 8'h00;
    end else begin
      state <= next_state;
      if (state == CPSQ_IDLE && start) begin
        op <= opcode;
        opnd <= operand;
        step <= 3'd0;
      end
      if (state == CPSQ_EXEC) begin
        step <= (step == 3'd4) ? step : step + 3'd1;
        if (step == 3'd2) ptr_lo <= lct_rdata; // first byte, one cycle late
      end
      cnt <= (state == CPSQ_IDLE) ? op_cycles : (cnt - CNT_W'(1));
      if (state == CPSQ_IDLE && start) cnt <= CNT_W'(CYC_BASIC);
      if (state == CPSQ_EXEC && step == 3'd0) cnt <= op_cycles;
    end
  end

  // memory port control: step 0 read, later steps use the data
  wire logic ex = (state == CPSQ_EXEC) & !bad_op;
  wire logic fin = ex & last;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lct_we <= 1'b0;
      lct_re <= 1'b0;
      lct_addr <= 8'h00;
      lct_wdata <= 8'h00;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      ram_addr <= 12'h000;
      ram_wdata <= 8'h00;
    end else begin
      lct_we <= 1'b0;
      lct_re <= 1'b0;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      if (ex && step == 3'd0) begin
        lct_re <= is_sub & !imm | is_tlu | is_st_x;
        lct_addr <= (is_sub_n | is_st_n) ? index : opnd;
        lct_we <= is_st_r | is_st_b | is_st_n;
        lct_wdata <= is_st_b ? index : acc;
      end
      if (ex && step == 3'd1 && is_tlu) begin
        lct_re <= 1'b1;
        lct_addr <= opnd + 8'h01;
      end
      if (ex && step == 3'd2 && is_st_x) begin
        ram_we <= 1'b1;
        ram_addr <= {lct_rdata[3:0], index};
        ram_wdata <= acc;
      end
      if (ex && step == 3'd3 && is_tlu) begin
        ram_re <= 1'b1;
        ram_addr <= tlu_ptr;
      end
    end
  end

  // registers and indicators, committed at the end of the timed window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc <= 8'h00;
      index <= 8'h00;
      carry_flag <= 1'b0;
      sign_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (fin) begin
      if (is_sub) begin
        if (in_b) index <= diff;
        else acc <= diff;
        carry_flag <= s_carry;
        sign_flag <= s_sign;
        zero_flag <= s_zero;
      end
      if (is_tqe | is_tqf) zero_flag <= s_zero;
      if (is_tlu) begin
        acc <= ram_rdata;
        sign_flag <= ram_rdata[7];
        zero_flag <= (ram_rdata == 8'h00);
      end
    end else if (state == CPSQ_IDLE && start) begin
      acc <= acc_in;
      index <= index_in;
    end
  end

  // wait: save context, scan, grant; restore when a suspended one wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      ctx_save <= 1'b0;
      ctx_restore <= 1'b0;
      ctx_channel <= '0;
      ctx_program <= 16'h0000;
      grant_valid <= 1'b0;
      grant_channel <= '0;
      suspended <= '0;
    end else begin
      busy <= (next_state != CPSQ_IDLE);
      done <= (next_state == CPSQ_DONE);
      illegal <= (state == CPSQ_EXEC) & bad_op;
      ctx_save <= 1'b0;
      ctx_restore <= 1'b0;
      grant_valid <= 1'b0;
      if (ex && step == 3'd0 && is_wait) begin
        ctx_save <= 1'b1;
        ctx_channel <= active_channel;
        ctx_program <= channel_program + 16'h0001;
        suspended[active_channel] <= 1'b1;
      end
      if (state == CPSQ_SCAN && win_any) begin
        grant_valid <= 1'b1;
        grant_channel <= win;
        if (resume) begin
          ctx_restore <= 1'b1;
          ctx_channel <= saved_ch[win];
          ctx_program <= saved_prog[win];
          suspended[win] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ex && step == 3'd0 && is_wait) begin
      saved_ch[active_channel] <= active_channel;
      saved_prog[active_channel] <= channel_program + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) wait_age <= '0;
    else if (ctx_save) wait_age <= CNT_W'(1);
    else if (grant_valid) wait_age <= '0;
    else if (wait_age != '0) wait_age <= wait_age + CNT_W'(1);
  end
  a_sub_carry: assert property (@(posedge clk) disable iff (!rstn)
    fin && is_sub |=> carry_flag == $past(s_carry))
    else $error("carry flag wrong after subtract");
  a_store_flags: assert property (@(posedge clk) disable iff (!rstn)
    fin && (is_st_r | is_st_b | is_st_n | is_st_x)
      |=> $stable(carry_flag) && $stable(zero_flag) && $stable(sign_flag))
    else $error("store changed flags");
  a_ext_illegal: assert property (@(posedge clk) disable iff (!rstn)
    state == CPSQ_EXEC && is_st_x && !ext_enable |=> illegal && !ram_we)
    else $error("extended store not refused");
  a_bad_opcode: assert property (@(posedge clk) disable iff (!rstn)
    state == CPSQ_EXEC && !known |=> illegal ##1 !busy)
    else $error("unassigned opcode not refused");
  a_queue_zero: assert property (@(posedge clk) disable iff (!rstn)
    fin && is_tqe |=> zero_flag == ($past(queue_head_ptr)
      == $past(queue_tail_ptr)) && $stable(acc))
    else $error("queue empty test wrong");
  a_wait_save: assert property (@(posedge clk) disable iff (!rstn)
    ex && step == 3'd0 && is_wait |=> ctx_save)
    else $error("wait did not save context");
  a_wait_grant: assert property (@(posedge clk) disable iff (!rstn)
    wait_age != '0 |-> wait_age <= CNT_W'(3000))
    else $error("wait not granted in time");
  a_lookup_acc: assert property (@(posedge clk) disable iff (!rstn)
    fin && is_tlu |=> acc == $past(ram_rdata) && sign_flag == acc[7])
    else $error("look-up byte not loaded");
  a_ext_write: assert property (@(posedge clk) disable iff (!rstn)
    ram_we |-> ram_wdata == acc)
    else $error("extended store data wrong");
  c_subtract: cover property (@(posedge clk) fin && is_sub);
  c_lookup: cover property (@(posedge clk) fin && is_tlu);
  c_wait_grant: cover property (@(posedge clk) grant_valid && ctx_restore);
  c_illegal: cover property (@(posedge clk) illegal);
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the store, subtract, look-up, queue and wait unit
`timescale 1ns/1ps
module testbench import cpsq_pkg::*;;
  logic clk = 0, resetn = 0, start = 0, config_a_order = 0;
  logic [7:0] opcode = 0, operand = 0, acc_in = 0, index_in = 0;
  logic [7:0] queue_head_ptr = 0, queue_tail_ptr = 0, config_a_data = 0;
  logic [15:0] service_req = 0, channel_program = 0;
  logic [3:0] active_channel = 0;
  logic [7:0] lct_rdata = 0, ram_rdata = 0;
  logic busy, done, illegal, carry_flag, sign_flag, zero_flag;
  logic [7:0] acc, index, lct_addr, lct_wdata, ram_wdata;
  logic lct_we, lct_re, ram_we, ram_re, ctx_save, ctx_restore, grant_valid;
  logic [11:0] ram_addr, rr_addr, rw_addr;
  logic [3:0] ctx_channel, grant_channel, gch;
  logic [15:0] ctx_program;
  logic [7:0] lct_mem [256];
  logic [7:0] ram_mem [4096];
  logic [7:0] rw_data;
  bit seen_ill, seen_rw, seen_save, seen_grant, seen_rst;
  int n_mismatch = 0, n_tests = 0, cyc;

  always #2.5 clk = ~clk;

  cpsq_exec i_cpsq_exec (.clk(clk), .resetn(resetn), .start(start),
    .opcode(opcode), .operand(operand), .acc_in(acc_in),
    .index_in(index_in), .queue_head_ptr(queue_head_ptr),
    .queue_tail_ptr(queue_tail_ptr), .config_a_order(config_a_order),
    .config_a_data(config_a_data), .service_req(service_req),
    .active_channel(active_channel), .channel_program(channel_program),
    .lct_rdata(lct_rdata), .ram_rdata(ram_rdata), .busy(busy),
    .done(done), .illegal(illegal), .acc(acc), .index(index),
    .carry_flag(carry_flag), .sign_flag(sign_flag),
    .zero_flag(zero_flag), .lct_we(lct_we), .lct_re(lct_re),
    .lct_addr(lct_addr), .lct_wdata(lct_wdata), .ram_we(ram_we),
    .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ctx_save(ctx_save), .ctx_restore(ctx_restore),
    .ctx_channel(ctx_channel), .ctx_program(ctx_program),
    .grant_valid(grant_valid), .grant_channel(grant_channel));

  // work table and local store answer one cycle after a read strobe
  always @(posedge clk) begin
    lct_rdata <= lct_re ? lct_mem[lct_addr] : ~lct_rdata;
    if (ram_re)
      ram_rdata <= ram_mem[ram_addr];
    if (lct_we)
      lct_mem[lct_addr] <= lct_wdata;
    if (ram_we)
      ram_mem[ram_addr] <= ram_wdata;
  end

  always @(posedge clk) begin
    if (illegal === 1'b1)
      seen_ill = 1;
    if (ram_we === 1'b1) begin
      seen_rw = 1;
      rw_addr = ram_addr;
      rw_data = ram_wdata;
    end
    if (ram_re === 1'b1)
      rr_addr = ram_addr;
    if (ctx_save === 1'b1)
      seen_save = 1;
    if (ctx_restore === 1'b1)
      seen_rst = 1;
    if (grant_valid === 1'b1) begin
      seen_grant = 1;
      gch = grant_channel;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_span(input string what, input int lo, input int hi);
    n_tests++;
    if (cyc < lo || cyc > hi) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi,
               cyc);
    end
  endtask

  function automatic logic [15:0] flags();
    return {13'h0, carry_flag, sign_flag, zero_flag};
  endfunction

  task automatic run(input logic [7:0] op, opd, a, x);
    seen_ill = 0;
    seen_rw = 0;
    seen_save = 0;
    seen_grant = 0;
    seen_rst = 0;
    opcode = op;
    operand = opd;
    acc_in = a;
    index_in = x;
    start = 1;
    @(posedge clk);
    #1 start = 0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 3000) begin
      @(posedge clk);
      #1 cyc++;
    end
    chk("done", 16'h0001, {15'h0, done});
    @(posedge clk);
    #1;
    chk("idle", 16'h0000, {15'h0, busy});
  endtask

  task automatic sub_t(input logic [7:0] op, opd, a, x, r,
                       input logic [2:0] f, input bit to_idx);
    run(op, opd, a, x);
    chk("sub result", {8'h00, r}, {8'h00, to_idx ? index : acc});
    chk("sub flags", {13'h0, f}, flags());
    chk_span("sub cycles", CYC_BASIC, CYC_BASIC + 4);
  endtask

  task automatic subtracts();
    lct_mem[8'h10] = 8'h85;
    lct_mem[8'hC8] = 8'hF4;
    sub_t(OP_SUB_R_LCT, 8'h10, 8'hC3, 8'h00, 8'h3E, 3'b100, 0);
    sub_t(OP_SUB_B_LCT, 8'h10, 8'h00, 8'h10, 8'h8B, 3'b010, 1);
    sub_t(OP_SUB_R_NDX, 8'h00, 8'hA1, 8'hC8, 8'hAD, 3'b010, 0);
    sub_t(OP_SUB_R_IMM, 8'h69, 8'h69, 8'h00, 8'h00, 3'b101, 0);
    sub_t(OP_SUB_B_IMM, 8'hA5, 8'h00, 8'h5B, 8'hB6, 3'b010, 1);
  endtask

  task automatic stores();
    run(OP_ST_R_LCT, 8'h20, 8'h77, 8'h01);
    chk("store acc", 16'h0077, {8'h00, lct_mem[8'h20]});
    chk("flags kept", 16'h0002, flags());
    run(OP_ST_B_LCT, 8'h21, 8'h02, 8'h66);
    chk("store index", 16'h0066, {8'h00, lct_mem[8'h21]});
    chk_span("store cycles", CYC_BASIC, CYC_BASIC + 4);
    run(OP_ST_R_NDX, 8'h00, 8'h55, 8'h30);
    chk("store indirect", 16'h0055, {8'h00, lct_mem[8'h30]});
    chk("flags kept", 16'h0002, flags());
  endtask

  task automatic illegals();
    run(OP_ST_EXT, 8'h40, 8'h9A, 8'h21);
    chk("ext refused", 16'h0001, {15'h0, seen_ill});
    chk("ext no write", 16'h0000, {15'h0, seen_rw});
    run(8'h40, 8'h00, 8'h00, 8'h00);
    chk("unassigned", 16'h0001, {15'h0, seen_ill});
    run(8'hD0, 8'h00, 8'h00, 8'h00);
    chk("unassigned", 16'h0001, {15'h0, seen_ill});
    chk("flags kept", 16'h0002, flags());
  endtask

  task automatic extended();
    config_a_data = 8'h10;
    config_a_order = 1;
    @(posedge clk);
    #1 config_a_order = 0;
    lct_mem[8'h40] = 8'h03;
    run(OP_ST_EXT, 8'h40, 8'h9A, 8'h21);
    chk("ext legal", 16'h0000, {15'h0, seen_ill});
    chk("ext addr", 16'h0321, {4'h0, rw_addr});
    chk("ext data", 16'h009A, {8'h00, rw_data});
    chk_span("ext cycles", CYC_EXT - 4, CYC_EXT + 8);
  endtask

  task automatic lookup();
    lct_mem[8'h50] = 8'hF0;
    lct_mem[8'h51] = 8'h02;
    ram_mem[12'h310] = 8'h80;
    run(OP_TLU, 8'h50, 8'h20, 8'h00);
    chk("tlu addr", 16'h0310, {4'h0, rr_addr});
    chk("tlu byte", 16'h0080, {8'h00, acc});
    chk("tlu flags", 16'h0002, {14'h0, sign_flag, zero_flag});
    chk_span("tlu cycles", CYC_TLU - 4, T_TLU_MAX_PS / CLK_PERIOD_PS + 8);
  endtask

  task automatic queues();
    queue_head_ptr = 8'h05;
    queue_tail_ptr = 8'h05;
    run(OP_TQE, 8'h00, 8'h00, 8'h00);
    chk("empty", 16'h0001, {15'h0, zero_flag});
    chk_span("tqe cycles", CYC_BASIC, CYC_BASIC + 4);
    queue_head_ptr = 8'h06;
    run(OP_TQE, 8'h00, 8'h00, 8'h00);
    chk("not empty", 16'h0000, {15'h0, zero_flag});
    queue_head_ptr = 8'h14;
    run(OP_TQF, 8'h00, 8'h00, 8'h00);
    chk("full", 16'h0001, {15'h0, zero_flag});
    chk_span("tqf cycles", CYC_TQF, CYC_TQF + 4);
    queue_tail_ptr = 8'h04;
    run(OP_TQF, 8'h00, 8'h00, 8'h00);
    chk("not full", 16'h0000, {15'h0, zero_flag});
    chk("sign kept", 16'h0001, {15'h0, sign_flag});
    chk("carry kept", 16'h0000, {15'h0, carry_flag});
  endtask

  task automatic suspend();
    service_req = 16'h0A00;
    active_channel = 4'h3;
    channel_program = 16'h1234;
    run(OP_WAIT, 8'h00, 8'h00, 8'h00);
    chk("ctx saved", 16'h0001, {15'h0, seen_save});
    chk("ctx program", 16'h1235, ctx_program);
    chk("ctx channel", 16'h0003, {12'h0, ctx_channel});
    chk("granted", 16'h0009, seen_grant ? {12'h0, gch} : 16'hFFFF);
    chk_span("wait cycles", CYC_WAIT - 4, CYC_WAIT + 40);
    chk("flags kept", 16'h0002, {14'h0, sign_flag, zero_flag});
    chk("no restore", 16'h0000, {15'h0, seen_rst});
    service_req = 16'h0028;
    active_channel = 4'h5;
    channel_program = 16'h2000;
    run(OP_WAIT, 8'h00, 8'h00, 8'h00);
    chk("ctx restored", 16'h0001, {15'h0, seen_rst});
    chk("resume program", 16'h1235, ctx_program);
    chk("resume channel", 16'h0003, {12'h0, ctx_channel});
    chk("granted", 16'h0003, seen_grant ? {12'h0, gch} : 16'hFFFF);
  endtask

  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    #1 resetn = 1;
    repeat (3) @(posedge clk);
    #1;
    subtracts();
    stores();
    illegals();
    extended();
    lookup();
    queues();
    suspend();
    close_out();
  end
endmodule
